// file: ssp_pkg.sv
// Package for the SPI/I2S serial port: register map, field layout, reset values, types.
// Assumes a single 20 MHz system clock domain; link pins are asynchronous.
package ssp_pkg;

  // ----------------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------------
  localparam logic [3:0] SSP_CTRL_OFS   = 4'h0;
  localparam logic [3:0] SSP_STATUS_OFS = 4'h1;
  localparam logic [3:0] SSP_DATA_OFS   = 4'h2;
  localparam logic [3:0] SSP_CRCPOLY_OFS = 4'h3;
  localparam logic [3:0] SSP_RXCRC_OFS  = 4'h4;
  localparam logic [3:0] SSP_TXCRC_OFS  = 4'h5;
  localparam logic [3:0] SSP_EVT_OFS    = 4'h6;
  localparam logic [3:0] SSP_MASK_OFS   = 4'h7;

  // ----------------------------------------------------------------------
  // Control register fields
  // ----------------------------------------------------------------------
  localparam int SSP_CTRL_EN_BIT      = 0;
  localparam int SSP_CTRL_MASTER_BIT  = 1;
  localparam int SSP_CTRL_I2S_BIT     = 2;
  localparam int SSP_CTRL_WSSTD_BIT   = 3;
  localparam int SSP_CTRL_CRCEN_BIT   = 4;
  localparam int SSP_CTRL_CRCNXT_BIT  = 5;
  localparam int SSP_CTRL_DMAEN_BIT   = 6;
  localparam int SSP_CTRL_CPOL_BIT    = 7;
  localparam int SSP_CTRL_DIV_LSB     = 8;
  localparam int SSP_CTRL_WIDTH       = 12;

  // ----------------------------------------------------------------------
  // Status and event fields
  // ----------------------------------------------------------------------
  localparam int SSP_ST_BUSY_BIT   = 0;
  localparam int SSP_ST_TXE_BIT    = 1;
  localparam int SSP_ST_RXF_BIT    = 2;
  localparam int SSP_ST_CRCERR_BIT = 3;
  localparam int SSP_ST_SEL_BIT    = 4;
  localparam int SSP_EVT_WIDTH     = 4;

  localparam logic [11:0] SSP_CTRL_RESET = 12'h000;
  localparam logic [7:0]  SSP_POLY_RESET = 8'h07;
  localparam logic [7:0]  SSP_WORD_BITS  = 8'h08;
  localparam logic [3:0]  SSP_WS_BUS_BITS = 4'h4;

  // ----------------------------------------------------------------------
  // Timing: slave idle-after-last-edge bound, in ns and cycles.
  // ----------------------------------------------------------------------
  localparam int SSP_CLK_NS       = 50;
  localparam int SSP_IDLE_NS      = 800;
  localparam int SSP_IDLE_CYCLES  = SSP_IDLE_NS / SSP_CLK_NS;

  typedef enum logic [1:0] {SSP_IDLE, SSP_WAIT_WS, SSP_SHIFT, SSP_DONE} ssp_phase_t;

  typedef struct packed {
    logic       ready;
    logic [7:0] data;
  } ssp_word_t;

endpackage

// file: ssp_crc8.sv
// CRC-8 step unit for the serial port: one bit in, next CRC out.
// Assumes the caller presents one bit per enabled step.
`timescale 1ns/1ps
module ssp_crc8 import ssp_pkg::*; (
  input  wire logic [7:0] crc_i,
  input  wire logic [7:0] poly_i,
  input  wire logic       bit_i,
  output logic      [7:0] crc_o
);

  logic fb;

  // The polynomial's lowest term is forced, so an even polynomial cannot corrupt the result.
  always_comb begin
    fb    = crc_i[7] ^ bit_i;
    crc_o = {crc_i[6:0], 1'b0} ^ ({8{fb}} & {poly_i[7:1], 1'b1});
  end

endmodule

// file: ssp_core.sv
// SPI/I2S serial port core: Avalon-MM registers, serial engine, CRC and interrupt.
// Assumes one 20 MHz clock; all link pins come from outside and are synchronised here.
//
// Function
// - I2S slave starts only at start level
// - CRC polynomial forced odd
// - Transmit empty status raised at second bit; its event only once busy drops
// - Receive full event at frame end
// - Slave select state readable in status
// - Disable finishes current frame, then busy drops
// - Busy high throughout frame transfer
// - CRC accumulates on sampled clock feedback
// - CRC accumulates until send-next, checked honestly
// - Software or DMA frame movement
//
// Decided for this implementation: the register addresses and register access over Avalon-MM.
`timescale 1ns/1ps
module ssp_core import ssp_pkg::*; (
  input  wire logic        clock_i,
  input  wire logic        reset_n_i,
  input  wire logic [3:0]  address_i,
  input  wire logic        read_i,
  input  wire logic        write_i,
  input  wire logic [31:0] writedata_i,
  output logic      [31:0] readdata_o,
  output logic             waitrequest_o,
  input  wire logic        sck_i,
  output logic             sck_o,
  output logic             sck_oe_o,
  input  wire logic        ws_i,
  output logic             ws_o,
  output logic             ws_oe_o,
  input  wire logic        select_n_i,
  input  wire logic        miso_i,
  output logic             mosi_o,
  output logic             dma_tx_req_o,
  output logic             dma_rx_req_o,
  output logic             irq_o
);

  typedef struct packed {
    logic [2:0]  sck_s;
    logic [1:0]  ws_s;
    logic [1:0]  sel_s;
    logic [1:0]  din_s;
    logic [11:0] ctrl;
    logic [7:0]  poly;
    ssp_word_t   tx;
    ssp_word_t   rx;
    logic [7:0]  shreg;
    logic [3:0]  bitcnt;
    logic [7:0]  divcnt;
    logic [4:0]  idlecnt;
    logic [7:0]  crc;
    logic [7:0]  rxcrc;
    logic        crc_phase;
    ssp_phase_t  phase;
    logic        busy;
    logic        tx_buffer_empty_flag;
    logic [3:0]  evt;
    logic [3:0]  mask;
    logic        sck_q;
    logic        mosi;
    logic        ws_q;
    logic        ws_oe;
    logic [3:0]  wscnt;
    logic [31:0] rdata;
    logic        ack;
    logic        waitreq;
    logic        irq;
    logic        dma_tx;
    logic        dma_rx;
  } ssp_state_t;

  ssp_state_t st;
  ssp_state_t next_st;
  logic [7:0] crc_next;
  logic       crc_bit;

  ssp_crc8 u_crc (
    .crc_i  (st.crc),
    .poly_i (st.poly),
    .bit_i  (crc_bit),
    .crc_o  (crc_next)
  );

  // The step unit always sees the sampled data pin; the state only takes its result on a sample.
  assign crc_bit = st.din_s[1];

  // -------------------------------------------------------------------
  // Serial engine, register bus and interrupt.
  // -------------------------------------------------------------------
  always_comb begin
    logic        en;
    logic        master;
    logic        i2s;
    logic        sck_rise;
    logic        sck_fall;
    logic        tick;
    logic        sample;
    logic        shift;
    logic        acc;
    logic        start_lvl;
    logic        frame_end;
    logic [3:0]  set_evt;
    logic        wr;
    logic        rd;
    next_st   = st;
    en        = st.ctrl[SSP_CTRL_EN_BIT];
    master    = st.ctrl[SSP_CTRL_MASTER_BIT];
    i2s       = st.ctrl[SSP_CTRL_I2S_BIT];
    sck_rise  = 1'b0;
    sck_fall  = 1'b0;
    tick      = 1'b0;
    sample    = 1'b0;
    shift     = 1'b0;
    acc       = 1'b0;
    frame_end = 1'b0;
    set_evt   = 4'h0;
    start_lvl = 1'b0;
    wr        = write_i && !st.ack;
    rd        = read_i && !st.ack;
    next_st.sck_s = {st.sck_s[1:0], sck_i};
    next_st.ws_s  = {st.ws_s[0], ws_i};
    next_st.sel_s = {st.sel_s[0], select_n_i};
    next_st.din_s = {st.din_s[0], miso_i};
    // Word select start level: high for standard I2S, low for justified formats.
    start_lvl = st.ctrl[SSP_CTRL_WSSTD_BIT] ? st.ws_s[1] : !st.ws_s[1];
    // Feedback edges come from the sampled clock pin, never from the internal toggle.
    sck_rise = st.sck_s[1] && !st.sck_s[2];
    sck_fall = !st.sck_s[1] && st.sck_s[2];
    if (st.divcnt == st.ctrl[11:SSP_CTRL_DIV_LSB] + 8'h00) begin
      next_st.divcnt = 8'h00;
      tick = 1'b1;
    end else begin
      next_st.divcnt = st.divcnt + 8'h01;
    end
    if (master) begin
      sample = sck_rise;
      shift  = sck_fall;
    end else begin
      sample = sck_rise && !st.sel_s[1];
      shift  = sck_fall && !st.sel_s[1];
    end
    case (st.phase)
      SSP_IDLE: begin
        next_st.busy = 1'b0;
        if (en && st.tx.ready) begin
          next_st.shreg    = st.tx.data;
          next_st.tx.ready = 1'b0;
          next_st.bitcnt   = 4'h0;
          next_st.mosi     = st.tx.data[7];
          next_st.phase    = (i2s && !master) ? SSP_WAIT_WS : SSP_SHIFT;
        end
      end
      SSP_WAIT_WS: begin
        if (start_lvl && sck_fall) begin
          next_st.phase = SSP_SHIFT;
        end
        if (!en) begin
          next_st.phase = SSP_IDLE;
        end
      end
      SSP_SHIFT: begin
        next_st.busy = 1'b1;
        if (master && tick) begin
          next_st.sck_q = !st.sck_q;
        end
        if (sample) begin
          acc = 1'b1;
          next_st.shreg  = {st.shreg[6:0], st.din_s[1]};
          next_st.bitcnt = st.bitcnt + 4'h1;
          if (st.bitcnt == 4'h1) begin
            next_st.tx_buffer_empty_flag = 1'b1;
          end
          if (st.bitcnt == SSP_WORD_BITS[3:0] - 4'h1) begin
            frame_end = 1'b1;
          end
        end
        if (shift) begin
          next_st.mosi = st.shreg[7];
        end
        if (frame_end) begin
          next_st.rx.data  = {st.shreg[6:0], st.din_s[1]};
          next_st.rx.ready = 1'b1;
          set_evt[SSP_ST_RXF_BIT] = 1'b1;
          next_st.sck_q = st.ctrl[SSP_CTRL_CPOL_BIT];
          next_st.idlecnt = 5'h00;
          next_st.phase = SSP_DONE;
        end
      end
      SSP_DONE: begin
        // A cleared enable lets the running frame end and then busy falls.
        next_st.idlecnt = st.idlecnt + 5'h01;
        if (st.idlecnt == SSP_IDLE_CYCLES[4:0] || master) begin
          next_st.busy  = 1'b0;
          next_st.phase = SSP_IDLE;
        end
      end
      default: next_st.phase = SSP_IDLE;
    endcase
    if (acc && st.ctrl[SSP_CTRL_CRCEN_BIT] && !st.crc_phase) begin
      next_st.crc = crc_next;
    end
    if (frame_end && st.crc_phase) begin
      next_st.rxcrc     = {st.shreg[6:0], st.din_s[1]};
      next_st.crc_phase = 1'b0;
      if ({st.shreg[6:0], st.din_s[1]} != st.crc) begin
        set_evt[SSP_ST_CRCERR_BIT] = 1'b1;
      end
    end
    if (frame_end && st.ctrl[SSP_CTRL_CRCNXT_BIT]) begin
      next_st.crc_phase = 1'b1;
      // The sent CRC must already hold the frame's last bit.
      next_st.tx.data   = next_st.crc;
      next_st.tx.ready  = 1'b1;
      next_st.ctrl[SSP_CTRL_CRCNXT_BIT] = 1'b0;
    end
    // Frame movement by software or DMA request lines.
    next_st.dma_tx = st.ctrl[SSP_CTRL_DMAEN_BIT] && !st.tx.ready && en;
    next_st.dma_rx = st.ctrl[SSP_CTRL_DMAEN_BIT] && st.rx.ready;
    if (st.tx_buffer_empty_flag && !st.busy) begin
      set_evt[SSP_ST_TXE_BIT] = 1'b1;
    end
    next_st.ack   = (read_i || write_i) && !st.ack;
    next_st.rdata = st.rdata;
    if (wr) begin
      if (address_i == SSP_CTRL_OFS) begin
        next_st.ctrl = writedata_i[11:0];
      end else if (address_i == SSP_DATA_OFS) begin
        next_st.tx.data  = writedata_i[7:0];
        next_st.tx.ready = 1'b1;
        next_st.tx_buffer_empty_flag      = 1'b0;
      end else if (address_i == SSP_CRCPOLY_OFS) begin
        next_st.poly = {writedata_i[7:1], 1'b1};
        next_st.crc  = 8'h00;
      end else if (address_i == SSP_EVT_OFS) begin
        next_st.evt = st.evt & ~writedata_i[3:0];
      end else if (address_i == SSP_MASK_OFS) begin
        next_st.mask = writedata_i[3:0];
      end
    end
    if (rd) begin
      next_st.rdata = 32'h0000_0000;
      if (address_i == SSP_CTRL_OFS) begin
        next_st.rdata = {20'h00000, st.ctrl};
      end else if (address_i == SSP_STATUS_OFS) begin
        next_st.rdata = {27'h0000000, st.sel_s[1], st.evt[SSP_ST_CRCERR_BIT],
                         st.rx.ready, st.tx_buffer_empty_flag, st.busy};
      end else if (address_i == SSP_DATA_OFS) begin
        next_st.rdata    = {24'h000000, st.rx.data};
        next_st.rx.ready = frame_end;
      end else if (address_i == SSP_CRCPOLY_OFS) begin
        next_st.rdata = {24'h000000, st.poly};
      end else if (address_i == SSP_RXCRC_OFS) begin
        next_st.rdata = {24'h000000, st.rxcrc};
      end else if (address_i == SSP_TXCRC_OFS) begin
        next_st.rdata = {24'h000000, st.crc};
      end else if (address_i == SSP_EVT_OFS) begin
        next_st.rdata = {28'h0000000, st.evt};
      end else if (address_i == SSP_MASK_OFS) begin
        next_st.rdata = {28'h0000000, st.mask};
      end
    end
    // Hardware set wins over a same-cycle software clear.
    next_st.evt = next_st.evt | set_evt;
    next_st.irq = |(next_st.evt & st.mask);
    // In I2S master the word select flips at each frame end, one channel per frame.
    if (master && i2s && frame_end) begin
      next_st.ws_q = !st.ws_q;
    end
    next_st.ws_oe   = next_st.ctrl[SSP_CTRL_MASTER_BIT] && next_st.ctrl[SSP_CTRL_I2S_BIT];
    next_st.waitreq = !next_st.ack;
    if (!st.busy) begin
      next_st.wscnt = 4'h0;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      st       <= '0;
      st.ctrl  <= SSP_CTRL_RESET;
      st.poly  <= SSP_POLY_RESET;
      st.phase <= SSP_IDLE;
      st.tx_buffer_empty_flag   <= 1'b1;
      st.waitreq <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign readdata_o    = st.rdata;
  assign waitrequest_o = st.waitreq;
  assign sck_o         = st.sck_q;
  assign sck_oe_o      = st.ctrl[SSP_CTRL_MASTER_BIT];
  assign ws_o          = st.ws_q;
  assign ws_oe_o       = st.ws_oe;
  assign mosi_o        = st.mosi;
  assign dma_tx_req_o  = st.dma_tx;
  assign dma_rx_req_o  = st.dma_rx;
  assign irq_o         = st.irq;

endmodule

// file: ssp_core_props.sv
// Checker for the serial port core: bus handshake, link pins and interrupt line.
// Sees only the core's ports and is bound to every instance of the core.
`timescale 1ns/1ps
module ssp_core_props (
  input wire logic        clock_i,
  input wire logic        reset_n_i,
  input wire logic [3:0]  address_i,
  input wire logic        read_i,
  input wire logic        write_i,
  input wire logic [31:0] readdata_o,
  input wire logic        waitrequest_o,
  input wire logic        sck_o,
  input wire logic        sck_oe_o,
  input wire logic        ws_oe_o,
  input wire logic        mosi_o,
  input wire logic        irq_o
);
  // ----------------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!reset_n_i);
  AST_WAIT_ONE: assert property ((read_i || write_i) && waitrequest_o |=> !waitrequest_o ##1 waitrequest_o) else $error("waitrequest not low for one cycle");
  AST_IDLE_WAIT: assert property (!(read_i || write_i) |=> waitrequest_o) else $error("waitrequest low without request");
  AST_RDATA_HOLD: assert property ($changed(readdata_o) |-> read_i && !waitrequest_o) else $error("read data moved outside a read");
  AST_UNMAPPED: assert property (read_i && !waitrequest_o && address_i[3] |-> readdata_o == 32'h0) else $error("unmapped read not zero");
  AST_IRQ_FALL: assert property ($fell(irq_o) |-> $past(write_i) || $past(write_i, 2)) else $error("interrupt dropped without a write");
  AST_WS_OE: assert property (!sck_oe_o |-> !ws_oe_o) else $error("word select driven outside master role");
  AST_MOSI_SETUP: assert property (sck_oe_o && $rose(sck_o) |-> $stable(mosi_o)) else $error("data moved at sampling edge");
  AST_OE_RISE: assert property ($rose(sck_oe_o) |-> $past(write_i) || $past(write_i, 2)) else $error("clock driven without a write");
  cover property ($rose(irq_o));
  cover property ($rose(sck_oe_o));
  cover property (read_i && !waitrequest_o && address_i[3]);
endmodule

bind ssp_core ssp_core_props u_props (.clock_i(clock_i), .reset_n_i(reset_n_i),
  .address_i(address_i), .read_i(read_i), .write_i(write_i), .readdata_o(readdata_o),
  .waitrequest_o(waitrequest_o), .sck_o(sck_o), .sck_oe_o(sck_oe_o), .ws_oe_o(ws_oe_o),
  .mosi_o(mosi_o), .irq_o(irq_o));

// file: ssp_peer_model.sv
// Far-side serial device: answers a frame MSB first and records what it hears.
// Assumes clock idle low; the bench pulses clear before each master frame.
`timescale 1ns/1ps
module ssp_peer_model (
  input  wire logic       sck_i,
  input  wire logic       mosi_i,
  input  wire logic       clear_i,
  input  wire logic [7:0] reply_i,
  output logic            miso_o,
  output logic      [7:0] got_o,
  output logic      [3:0] in_cnt_o
);
  logic [3:0] out_cnt;
  // After the frame the line shows the inverse of the last bit, never a stale copy.
  assign miso_o = (out_cnt < 4'h8) ? reply_i[3'h7 - out_cnt[2:0]] : ~reply_i[0];
  always @(posedge sck_i or posedge clear_i) begin
    if (clear_i) begin
      got_o <= 8'h00;
      in_cnt_o <= 4'h0;
    end else begin
      got_o <= {got_o[6:0], mosi_i};
      in_cnt_o <= in_cnt_o + 4'h1;
    end
  end
  always @(negedge sck_i or posedge clear_i) begin
    if (clear_i) out_cnt <= 4'h0;
    else if (out_cnt != 4'h8) out_cnt <= out_cnt + 4'h1;
  end
endmodule

// file: ssp_core_tb.sv
// Testbench for the serial port core: registers, master and slave frames, interrupt.
// Assumes the peer model and the checker are compiled before this file.
`timescale 1ns/1ps
module ssp_core_tb import ssp_pkg::*; ();
  logic        clock_i = 1'b0, reset_n_i = 1'b0, read_i = 1'b0, write_i = 1'b0;
  logic        select_n_i = 1'b1, ext_sck = 1'b0, ext_sdi = 1'b0, clr = 1'b1;
  logic        ext_ws = 1'b1, dma_tx, dma_rx;
  logic [3:0]  address_i = 4'h0, bits;
  logic [31:0] writedata_i = 32'h0, readdata_o, q;
  logic        waitrequest_o, sck_o, sck_oe_o, ws_o, ws_oe_o, mosi_o, peer_miso, irq_o;
  logic [7:0]  got;
  int          num_errors = 0, check_count = 0;
  wire logic   sck_pin = sck_oe_o ? sck_o : ext_sck;
  wire logic   miso_pin = sck_oe_o ? peer_miso : ext_sdi;
  wire logic   ws_pin = ws_oe_o ? ws_o : ext_ws;

  always #25 clock_i = ~clock_i;

  ssp_core dut (.clock_i(clock_i), .reset_n_i(reset_n_i), .address_i(address_i),
    .read_i(read_i), .write_i(write_i), .writedata_i(writedata_i), .readdata_o(readdata_o),
    .waitrequest_o(waitrequest_o), .sck_i(sck_pin), .sck_o(sck_o), .sck_oe_o(sck_oe_o),
    .ws_i(ws_pin), .ws_o(ws_o), .ws_oe_o(ws_oe_o), .select_n_i(select_n_i),
    .miso_i(miso_pin), .mosi_o(mosi_o), .dma_tx_req_o(dma_tx), .dma_rx_req_o(dma_rx),
    .irq_o(irq_o));
  ssp_peer_model peer (.sck_i(sck_pin), .mosi_i(mosi_o), .clear_i(clr), .reply_i(8'h3c),
    .miso_o(peer_miso), .got_o(got), .in_cnt_o(bits));

  // ----------------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------------
  task automatic chk(input logic [31:0] got_v, input logic [31:0] exp_v);
    check_count++;
    if (got_v !== exp_v) begin
      num_errors++;
      $display("[ERR] %0t ns: got %h expected %h", $time, got_v, exp_v);
    end
  endtask
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    int n;
    n = 0;
    write_i <= wr;
    read_i <= ~wr;
    address_i <= a;
    writedata_i <= d;
    @(posedge clock_i);
    while (waitrequest_o !== 1'b0 && n < 20) begin
      @(posedge clock_i);
      n++;
    end
    r = readdata_o;
    write_i <= 1'b0;
    read_i <= 1'b0;
    if (n == 20) chk(32'h0, 32'h1);
    @(posedge clock_i);
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask
  task automatic rdc(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] r;
    bus(1'b0, a, 32'h0, r);
    chk(r & m, e);
  endtask
  task automatic poll(input int b, input logic v);
    int n;
    n = 0;
    q = 32'h0;
    q[b] = ~v;
    while (q[b] !== v && n < 200) begin
      bus(1'b0, SSP_STATUS_OFS, 32'h0, q);
      n++;
    end
  endtask
  task automatic pclr;
    clr <= 1'b1;
    @(posedge clock_i);
    clr <= 1'b0;
    @(posedge clock_i);
  endtask
  task automatic sck_pulse(input logic d);
    ext_sdi <= d;
    repeat (4) @(posedge clock_i);
    ext_sck <= 1'b1;
    repeat (4) @(posedge clock_i);
    ext_sck <= 1'b0;
  endtask
  function automatic logic [7:0] crc_ref(input logic [7:0] c, input logic [7:0] d);
    logic [7:0] r;
    r = c;
    for (int i = 7; i >= 0; i--) begin
      r = {r[6:0], 1'b0} ^ ((r[7] ^ d[i]) ? SSP_POLY_RESET : 8'h00);
    end
    return r;
  endfunction
  task automatic close_out;
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic t_regs;
    rdc(SSP_CTRL_OFS, 32'hfff, {20'h0, SSP_CTRL_RESET});
    rdc(SSP_STATUS_OFS, 32'h7, 32'h2);
    rdc(SSP_CRCPOLY_OFS, 32'hff, 32'h7);
    wr(SSP_CRCPOLY_OFS, 32'h6);
    rdc(SSP_CRCPOLY_OFS, 32'hff, 32'h7);
    wr(4'h8, 32'hffffffff);
    rdc(4'h8, 32'hffffffff, 32'h0);
    $display("test regs done");
  endtask
  task automatic t_master;
    pclr;
    wr(SSP_MASK_OFS, 32'h4);
    wr(SSP_CTRL_OFS, 32'h353);
    wr(SSP_DATA_OFS, 32'ha5);
    rdc(SSP_STATUS_OFS, 32'h1, 32'h1);
    poll(SSP_ST_BUSY_BIT, 1'b0);
    chk(q[0], 1'b0);
    chk(got, 8'ha5);
    chk(bits, 4'h8);
    chk(dma_rx, 1'b1);
    chk(dma_tx, 1'b1);
    rdc(SSP_TXCRC_OFS, 32'hff, {24'h0, crc_ref(8'h00, 8'h3c)});
    rdc(SSP_STATUS_OFS, 32'h8, 32'h0);
    rdc(SSP_DATA_OFS, 32'hff, 32'h3c);
    chk(dma_rx, 1'b0);
    rdc(SSP_EVT_OFS, 32'h4, 32'h4);
    chk(irq_o, 1'b1);
    wr(SSP_EVT_OFS, 32'h4);
    repeat (3) @(posedge clock_i);
    chk(irq_o, 1'b0);
    $display("test master done");
  endtask
  task automatic t_disable;
    pclr;
    wr(SSP_DATA_OFS, 32'h81);
    poll(SSP_ST_TXE_BIT, 1'b1);
    chk(q[1], 1'b1);
    chk(bits != 4'h0 && bits < 4'h4, 1'b1);
    wr(SSP_CTRL_OFS, 32'h302);
    poll(SSP_ST_BUSY_BIT, 1'b0);
    chk(q[0], 1'b0);
    chk({bits, got}, 12'h881);
    $display("test disable done");
  endtask
  task automatic t_slave;
    logic [31:0] s0;
    logic [7:0] b;
    b = 8'h5a;
    wr(SSP_CTRL_OFS, 32'h1);
    wr(SSP_EVT_OFS, 32'hf);
    wr(SSP_DATA_OFS, 32'h96);
    bus(1'b0, SSP_STATUS_OFS, 32'h0, s0);
    select_n_i <= 1'b0;
    repeat (4) @(posedge clock_i);
    bus(1'b0, SSP_STATUS_OFS, 32'h0, q);
    chk(q[4] ^ s0[4], 1'b1);
    for (int i = 7; i >= 0; i--) begin
      sck_pulse(b[i]);
    end
    @(posedge clock_i);
    repeat (20) @(posedge clock_i);
    rdc(SSP_STATUS_OFS, 32'h1, 32'h0);
    rdc(SSP_EVT_OFS, 32'h4, 32'h4);
    rdc(SSP_DATA_OFS, 32'hff, 32'h5a);
    select_n_i <= 1'b1;
    $display("test slave done");
  endtask
  task automatic t_i2s;
    logic [7:0] b;
    b = 8'hc3;
    select_n_i <= 1'b0;
    ext_ws <= 1'b0;
    wr(SSP_EVT_OFS, 32'hf);
    wr(SSP_CTRL_OFS, 32'hd);
    wr(SSP_DATA_OFS, 32'h42);
    sck_pulse(1'b1);
    sck_pulse(1'b1);
    rdc(SSP_STATUS_OFS, 32'h1, 32'h0);
    ext_ws <= 1'b1;
    sck_pulse(1'b0);
    for (int i = 7; i >= 0; i--) begin
      sck_pulse(b[i]);
    end
    repeat (20) @(posedge clock_i);
    rdc(SSP_STATUS_OFS, 32'h1, 32'h0);
    rdc(SSP_DATA_OFS, 32'hff, 32'hc3);
    rdc(SSP_EVT_OFS, 32'h4, 32'h4);
    select_n_i <= 1'b1;
    $display("test i2s done");
  endtask

  initial begin
    repeat (8) @(posedge clock_i);
    reset_n_i <= 1'b1;
    clr <= 1'b0;
    @(posedge clock_i);
    t_regs;
    t_master;
    t_disable;
    t_slave;
    t_i2s;
    close_out;
  end
  initial begin
    repeat (5000) @(posedge clock_i);
    num_errors++;
    $display("[ERR] %0t ns: watchdog expired", $time);
    close_out;
  end
endmodule
